// ### hdl/wdwt_regs.svh
`ifndef WDWT_REGS_SVH
`define WDWT_REGS_SVH
// Restart key that zeroes the count.
`define WDWT_KEY 8'hA5
// Width of the period selector fields.
`define WDWT_SEL_W 4
// Largest valid period code; codes above it are clamped.
`define WDWT_SEL_MAX 4'hB
// Shortest period in counting-clock cycles for code zero.
`define WDWT_BASE_CYC 8
// Counter width, enough for the longest closed plus open period.
`define WDWT_CNT_W 16
`endif

// ### hdl/wdwt_pkg.sv
package wdwt_pkg;
	// Configuration fields applied on the counting side.
	typedef struct packed {
		logic run;
		logic window_mode_on;
		logic [3:0] shut_span_sel;
		logic [3:0] timeout_length_sel;
		logic [3:0] warning_offset_sel;
	} wdwt_cfg_t;
	// Power-on settings from the non-volatile user row.
	typedef struct packed {
		logic run;
		logic permanent_run_lock;
		logic window_mode_on;
		logic [3:0] shut_span_sel;
		logic [3:0] timeout_length_sel;
		logic [3:0] warning_offset_sel;
	} wdwt_nvm_t;
	typedef enum logic [1:0] {
		WDWT_STOP,
		WDWT_CLOSED,
		WDWT_OPEN
	} wdwt_state_t;
endpackage

// ### hdl/wdwt_sync.sv
`timescale 1ns/1ns
// Three-stage synchroniser for a level from the counting-clock domain.
module wdwt_sync (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic async_in,
	output logic sync_out
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	// The first stage feeds only the second; output changes when 2 and 3 agree.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			s1_q <= async_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				sync_out <= s3_q;
			end
		end
	end
endmodule

// ### hdl/wdwt_top.sv
`timescale 1ns/1ns
`include "wdwt_regs.svh"
// Notes on behaviour
// - Run enable off stops the counter unless the lock is set.
// - Protected writes are dropped while enabled or enabling.
// - Setup and warning control writes during a disable are held and applied afterwards.
// - Power-on loads run, lock, window and period fields from settings.
// - Writing one to run enable starts, zero stops the watchdog.
// - Disable is honoured only while the lock is clear.
// - Normal mode resets the system when the timeout elapses unrestarted.
// - Key 0xA5 to restart zeroes the count and starts a new period.
// - Any other restart value causes an immediate system reset.
// - Timeout selector picks one of twelve periods.
// - Warning enable defaults clear; set and clear by separate one-writes.
// - Normal mode raises the warning at the offset-selected moment.
// - Window mode: restart during closed window causes reset.
// - Closed span then open span; total timeout is their sum.
// - Window mode warning fires when the open window begins.
// - Lock set keeps the watchdog running regardless of run enable.
// - Lock clears only on power-on reset.
// - Lock set makes setup and warning control read-only.
// - Window mode bit stays writable while locked.
// - Interrupt enable set and clear stay writable while locked.
// - Interrupt request equals flag and enable until cleared or reset.
// - Control writes and correct-key restart writes raise sync_pending until crossed.
// - Warning offset counts cycles from period start; reset can win.
module wdwt_top #(
	parameter int BASE_CYC = `WDWT_BASE_CYC,
	parameter int CNT_W = `WDWT_CNT_W
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic count_tick,
	input wire wdwt_pkg::wdwt_nvm_t nvm_settings,
	input wire logic ctrl_wr,
	input wire logic ctrl_run_wdata,
	input wire logic ctrl_lock_wdata,
	input wire logic ctrl_window_wdata,
	input wire logic setup_wr,
	input wire logic [3:0] shut_span_wdata,
	input wire logic [3:0] timeout_length_wdata,
	input wire logic warn_ctrl_wr,
	input wire logic [3:0] warning_offset_wdata,
	input wire logic restart_wr,
	input wire logic [7:0] restart_wdata,
	input wire logic irq_enable_set_wr,
	input wire logic irq_enable_clear_wr,
	input wire logic irq_flag_clear_wr,
	output logic bus_stall,
	output wdwt_pkg::wdwt_cfg_t cfg_rdata,
	output logic run_rdata,
	output logic permanent_run_lock,
	output logic early_warning_en,
	output logic early_warning_flag,
	output logic sync_pending,
	output logic irq,
	output logic system_reset
);
	import wdwt_pkg::*;

	// Elaboration check: the period table must fit the counter.
	if (CNT_W < 16 || CNT_W > 30 || BASE_CYC < 1) begin : g_bad_param
		$error("wdwt_top: counter width or base count not supported");
	end

	// Bus-side registers; only run, lock and restart reach the counter through a handshake, the rest directly.
	logic run_q;
	logic lock_q;
	logic win_q;
	logic [3:0] shut_q;
	logic [3:0] tlen_q;
	logic [3:0] woff_q;
	logic ew_en_q;
	logic ew_flag_q;
	logic sync_req_q;
	logic rst_out_q;
	logic held_setup_q;
	logic [3:0] held_shut_q;
	logic [3:0] held_tlen_q;
	logic held_warn_q;
	logic [3:0] held_woff_q;
	logic restart_pend_q;
	logic restart_flag_q;
	// Counting-side state.
	wdwt_state_t state_q;
	logic [CNT_W-1:0] cnt_q;
	logic ack_q;
	logic active_q;
	logic ew_evt_q;
	logic tick_q;
	logic tick_sync;
	logic ack_sync;
	logic ack_seen_q;
	logic ew_evt_sync;
	logic ew_evt_seen_q;
	logic por_q;

	// The tick comes from a slow, unrelated oscillator, so it is resynchronised.
	wdwt_sync u_tick (
		.mclk(mclk),
		.rst_n(rst_n),
		.async_in(count_tick),
		.sync_out(tick_sync)
	);

	// Counting-side state is produced here, on the tick edge, then fed back.
	wire tick_rise = tick_sync && !tick_q;
	wire active_run = run_q || lock_q;
	wire enabling = active_run || active_q;
	wire disabling = !active_run && active_q;
	wire sync_done = ack_q != ack_seen_q;
	wire ew_pulse = ew_evt_q != ew_evt_seen_q;

	function automatic logic [CNT_W-1:0] period_cyc(input logic [3:0] sel);
		logic [3:0] s;
		s = (sel > `WDWT_SEL_MAX) ? `WDWT_SEL_MAX : sel;
		period_cyc = CNT_W'(BASE_CYC) << s;
	endfunction

	wire [CNT_W-1:0] open_timeout = period_cyc(tlen_q);
	wire [CNT_W-1:0] closed_timeout = period_cyc(shut_q);
	wire [CNT_W-1:0] warn_cyc = period_cyc(woff_q);

	wire prot_ok = !enabling && !lock_q;
	wire prot_hold = disabling && !lock_q;
	wire bad_key = restart_wr && restart_wdata != `WDWT_KEY;
	wire early_restart = restart_flag_q && state_q == WDWT_CLOSED;
	wire good_restart = restart_flag_q && state_q != WDWT_CLOSED;
	assign bus_stall = sync_pending && (ctrl_wr || restart_wr);
	wire ctrl_take = ctrl_wr && !sync_pending;
	wire restart_take = restart_wr && !sync_pending;

	// Early warning match differs between the two modes.
	// normal mode warning point
	wire ew_normal = !win_q && state_q == WDWT_OPEN &&
		cnt_q + 1'b1 == warn_cyc && warn_cyc < open_timeout;
	wire ew_window = win_q && state_q == WDWT_CLOSED &&
		cnt_q + 1'b1 == closed_timeout;
	wire expire = state_q == WDWT_OPEN && cnt_q + 1'b1 >= open_timeout;

	// Power-on detect: first clocked cycle after release loads the settings.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			por_q <= 1'b1;
		end else begin
			por_q <= 1'b0;
		end
	end

	// Control register: run and lock, window bit.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			run_q <= 1'b0;
			lock_q <= 1'b0;
			win_q <= 1'b0;
		end else if (por_q) begin
			run_q <= nvm_settings.run;
			lock_q <= nvm_settings.permanent_run_lock;
			win_q <= nvm_settings.window_mode_on;
		end else if (ctrl_take) begin
			if (!lock_q) begin
				run_q <= ctrl_run_wdata;
			end
			if (ctrl_lock_wdata && !enabling) begin
				lock_q <= 1'b1;
			end
			if (!enabling || lock_q) begin
				win_q <= ctrl_window_wdata;
			end
		end
	end

	// Setup and warning control, with held writes during a disable.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			shut_q <= 4'h0;
			tlen_q <= 4'h0;
			woff_q <= 4'h0;
			held_setup_q <= 1'b0;
			held_warn_q <= 1'b0;
			held_shut_q <= 4'h0;
			held_tlen_q <= 4'h0;
			held_woff_q <= 4'h0;
		end else if (por_q) begin
			shut_q <= nvm_settings.shut_span_sel;
			tlen_q <= nvm_settings.timeout_length_sel;
			woff_q <= nvm_settings.warning_offset_sel;
		end else begin
			if (setup_wr && prot_ok) begin
				shut_q <= shut_span_wdata;
				tlen_q <= timeout_length_wdata;
			end else if (setup_wr && prot_hold) begin
				held_setup_q <= 1'b1;
				held_shut_q <= shut_span_wdata;
				held_tlen_q <= timeout_length_wdata;
			end else if (held_setup_q && !enabling) begin
				shut_q <= held_shut_q;
				tlen_q <= held_tlen_q;
				held_setup_q <= 1'b0;
			end
			if (warn_ctrl_wr && prot_ok) begin
				woff_q <= warning_offset_wdata;
			end else if (warn_ctrl_wr && prot_hold) begin
				held_warn_q <= 1'b1;
				held_woff_q <= warning_offset_wdata;
			end else if (held_warn_q && !enabling) begin
				woff_q <= held_woff_q;
				held_warn_q <= 1'b0;
			end
		end
	end

	// Interrupt enable, flag and synchronisation busy; sets win over clears.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ew_en_q <= 1'b0;
			ew_flag_q <= 1'b0;
			ew_evt_seen_q <= 1'b0;
			sync_req_q <= 1'b0;
			ack_seen_q <= 1'b0;
			restart_pend_q <= 1'b0;
		end else begin
			if (irq_enable_set_wr) begin
				ew_en_q <= 1'b1;
			end else if (irq_enable_clear_wr) begin
				ew_en_q <= 1'b0;
			end
			ew_evt_seen_q <= ew_evt_q;
			if (ew_pulse) begin
				ew_flag_q <= 1'b1;
			end else if (irq_flag_clear_wr) begin
				ew_flag_q <= 1'b0;
			end
			ack_seen_q <= ack_q;
			// power-on load crossing
			// A loaded run enable reaches the counter only through a crossing.
			if (por_q || ctrl_take || (restart_take && !bad_key)) begin
				sync_req_q <= 1'b1;
				restart_pend_q <= restart_take;
			end else if (sync_done) begin
				sync_req_q <= 1'b0;
				restart_pend_q <= 1'b0;
			end
		end
	end

	// Counter: a request is acknowledged one counting tick later.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			tick_q <= 1'b0;
			state_q <= WDWT_STOP;
			cnt_q <= '0;
			ack_q <= 1'b0;
			active_q <= 1'b0;
			ew_evt_q <= 1'b0;
			restart_flag_q <= 1'b0;
			rst_out_q <= 1'b0;
		end else begin
			tick_q <= tick_sync;
			restart_flag_q <= 1'b0;
			// A stopped counter may still sit in the open state for one tick.
			if (bad_key || early_restart || (tick_rise && expire &&
					active_q)) begin
				rst_out_q <= 1'b1;
			end
			if (tick_rise) begin
				if (sync_req_q && !sync_done) begin
					ack_q <= !ack_q;
					active_q <= active_run;
					restart_flag_q <= restart_pend_q;
				end
				if (ew_normal || ew_window) begin
					ew_evt_q <= !ew_evt_q;
				end
				unique case (state_q)
					WDWT_STOP: begin
						cnt_q <= '0;
						if (active_q) begin
							state_q <= win_q ? WDWT_CLOSED : WDWT_OPEN;
						end
					end
					WDWT_CLOSED: begin
						cnt_q <= cnt_q + 1'b1;
						if (cnt_q + 1'b1 >= closed_timeout) begin
							state_q <= WDWT_OPEN;
							cnt_q <= '0;
						end
					end
					WDWT_OPEN: begin
						cnt_q <= cnt_q + 1'b1;
					end
				endcase
				if (!active_q) begin
					state_q <= WDWT_STOP;
				end
			end
			if (good_restart) begin
				cnt_q <= '0;
				state_q <= win_q ? WDWT_CLOSED : WDWT_OPEN;
			end
		end
	end

	assign irq = ew_flag_q && ew_en_q;
	assign sync_pending = sync_req_q;
	assign system_reset = rst_out_q;
	assign run_rdata = run_q;
	assign permanent_run_lock = lock_q;
	assign early_warning_en = ew_en_q;
	assign early_warning_flag = ew_flag_q;
	assign cfg_rdata = '{run: active_q, window_mode_on: win_q,
		shut_span_sel: shut_q, timeout_length_sel: tlen_q,
		warning_offset_sel: woff_q};
endmodule

// ### verif/wdwt_top_checker.sv
`timescale 1ns/1ns
// Port-level watch on the watchdog top; one clock, one reset.
module wdwt_top_checker (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ctrl_wr,
	input wire logic restart_wr,
	input wire logic [7:0] restart_wdata,
	input wire logic irq_enable_set_wr,
	input wire logic irq_enable_clear_wr,
	input wire logic bus_stall,
	input wire wdwt_pkg::wdwt_cfg_t cfg_rdata,
	input wire logic permanent_run_lock,
	input wire logic early_warning_en,
	input wire logic early_warning_flag,
	input wire logic sync_pending,
	input wire logic irq,
	input wire logic system_reset
);
	import wdwt_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// A wrong key that is taken starts a forced reset.
	sequence bad_key_s;
		restart_wr && !sync_pending && restart_wdata != 8'hA5;
	endsequence
	// A taken synchronised write; a bad key is left out on purpose.
	sequence sync_wr_s;
		!sync_pending && (ctrl_wr || restart_wr && restart_wdata == 8'hA5);
	endsequence
	chk_bad_key: assert property (bad_key_s |=> system_reset)
		else $error("wrong key gave no reset");
	chk_reset_sticky: assert property (system_reset |=> system_reset)
		else $error("system reset dropped");
	chk_lock_sticky: assert property (
		permanent_run_lock |=> permanent_run_lock)
		else $error("lock dropped");
	chk_sync_set: assert property (sync_wr_s |=> sync_pending)
		else $error("sync pending not raised");
	chk_sync_bound: assert property (
		$rose(sync_pending) |-> ##[1:40] !sync_pending)
		else $error("sync pending stuck");
	chk_stall_when: assert property (
		bus_stall == ((ctrl_wr || restart_wr) && sync_pending))
		else $error("bus stall wrong");
	chk_irq_and: assert property (
		irq == (early_warning_flag && early_warning_en))
		else $error("irq not flag and enable");
	chk_en_set: assert property (
		irq_enable_set_wr && !irq_enable_clear_wr |=> early_warning_en)
		else $error("enable set failed");
	chk_en_clear: assert property (
		irq_enable_clear_wr && !irq_enable_set_wr |=> !early_warning_en)
		else $error("enable clear failed");
	chk_cfg_locked: assert property (
		permanent_run_lock |=> $stable(cfg_rdata.timeout_length_sel) &&
		$stable(cfg_rdata.shut_span_sel) &&
		$stable(cfg_rdata.warning_offset_sel))
		else $error("period fields changed while locked");
endmodule

// ### verif/wdwt_top_tb.sv
`timescale 1ns/1ns
module wdwt_top_tb;
	import wdwt_pkg::*;
	logic mclk = 1'b0, rst_n = 1'b0;
	logic [2:0] tc = '0;
	wdwt_nvm_t nvm_settings = '0;
	logic ctrl_wr = '0, ctrl_run_wdata = '0, ctrl_lock_wdata = '0;
	logic ctrl_window_wdata = '0, setup_wr = '0, warn_ctrl_wr = '0;
	logic [3:0] shut_span_wdata = '0, timeout_length_wdata = '0;
	logic [3:0] warning_offset_wdata = '0;
	logic restart_wr = '0, irq_enable_set_wr = '0;
	logic irq_enable_clear_wr = '0, irq_flag_clear_wr = '0;
	logic [7:0] restart_wdata = '0;
	logic bus_stall, run_rdata, permanent_run_lock, early_warning_en;
	logic early_warning_flag, sync_pending, irq, system_reset;
	wdwt_cfg_t cfg_rdata, ec;
	wdwt_nvm_t nv;
	int error_cnt = 0;
	int checks = 0;
	integer seed = 32'h013e_eea9;
	// Period fields are cut to one tick per unit so runs stay short.
	wdwt_top #(.BASE_CYC(1)) u_wdwt_top (.mclk, .rst_n,
		.count_tick(tc[2]), .nvm_settings, .ctrl_wr, .ctrl_run_wdata,
		.ctrl_lock_wdata, .ctrl_window_wdata, .setup_wr, .shut_span_wdata,
		.timeout_length_wdata, .warn_ctrl_wr, .warning_offset_wdata,
		.restart_wr, .restart_wdata, .irq_enable_set_wr, .irq_enable_clear_wr,
		.irq_flag_clear_wr, .bus_stall, .cfg_rdata, .run_rdata,
		.permanent_run_lock, .early_warning_en, .early_warning_flag,
		.sync_pending, .irq, .system_reset);
	// Main clock, and a slow count clock of eight main periods.
	initial forever #50 mclk = ~mclk;
	always @(posedge mclk) tc <= tc + 3'h1;
	// Cuts a hang short.
	initial begin
		repeat (30000) @(posedge mclk);
		error_cnt++;
		end_of_test;
	end
	task automatic end_of_test;
		if (error_cnt == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic cmp_bit(string nm, logic e, logic g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic cmp_cfg(wdwt_cfg_t e);
		checks++;
		if (cfg_rdata !== e) begin
			error_cnt++;
			$display("Error cfg_rdata expected %h seen %h", e, cfg_rdata);
		end
	endtask
	function automatic wdwt_cfg_t exp_cfg(wdwt_nvm_t n);
		return {n.run, n.window_mode_on, n.shut_span_sel,
			n.timeout_length_sel, n.warning_offset_sel};
	endfunction
	// Main cycles to wait for a period code, with room for the crossing.
	function automatic int span(logic [3:0] c);
		return (16 << c) + 40;
	endfunction
	task automatic boot(wdwt_nvm_t n);
		rst_n <= 1'b0;
		nvm_settings <= n;
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		// The power-on load crosses like a control write; wait it out.
		repeat (60) if (sync_pending) @(posedge mclk);
	endtask
	// Strobes last one cycle; every sync write waits for its crossing.
	task automatic fire;
		@(posedge mclk);
		{ctrl_wr, setup_wr, warn_ctrl_wr, restart_wr} <= '0;
		{irq_enable_set_wr, irq_enable_clear_wr, irq_flag_clear_wr} <= '0;
		#1;
	endtask
	task automatic wr_ctrl(logic r, logic l, logic w);
		@(posedge mclk);
		{ctrl_wr, ctrl_run_wdata, ctrl_lock_wdata, ctrl_window_wdata}
			<= {1'b1, r, l, w};
		fire;
		repeat (60) if (sync_pending) @(posedge mclk);
	endtask
	task automatic wr_setup(logic [3:0] s, logic [3:0] t, logic [3:0] o);
		@(posedge mclk);
		{setup_wr, shut_span_wdata, timeout_length_wdata} <= {1'b1, s, t};
		{warn_ctrl_wr, warning_offset_wdata} <= {1'b1, o};
		fire;
	endtask
	task automatic restart(logic [7:0] d);
		@(posedge mclk);
		{restart_wr, restart_wdata} <= {1'b1, d};
		fire;
		if (d == 8'hA5) repeat (60) if (sync_pending) @(posedge mclk);
	endtask
	task automatic irq_op(logic [2:0] m);
		@(posedge mclk);
		{irq_enable_set_wr, irq_enable_clear_wr, irq_flag_clear_wr} <= m;
		fire;
	endtask
	initial begin
		logic [3:0] t, o, s;
		logic [7:0] d;
		t = 4'h2 + {2'b00, 2'($random(seed))};
		o = t - 4'h1 - {3'b000, 1'($random(seed))};
		s = 4'h3 + {3'b000, 1'($random(seed))};
		nv = '0;
		nv.shut_span_sel = s;
		boot(nv);
		cmp_cfg(exp_cfg(nv));
		cmp_bit("early_warning_en", 1'b0, early_warning_en);
		ec = exp_cfg(nv);
		ec.timeout_length_sel = t;
		ec.warning_offset_sel = o;
		ec.run = 1'b1;
		wr_setup(s, t, o);
		irq_op(3'h4);
		wr_ctrl(1'b1, 1'b0, 1'b0);
		cmp_cfg(ec);
		cmp_bit("run_rdata", 1'b1, run_rdata);
		// A control write held while its own crossing runs is stalled.
		@(posedge mclk);
		ctrl_wr <= 1'b1;
		@(posedge mclk);
		#1;
		cmp_bit("bus_stall", 1'b1, bus_stall);
		fire;
		repeat (60) if (sync_pending) @(posedge mclk);
		wr_setup(s, ~t, ~o);
		cmp_cfg(ec);
		restart(8'hA5);
		repeat (span(o)) if (!early_warning_flag) @(posedge mclk);
		cmp_bit("early_warning_flag", 1'b1, early_warning_flag);
		cmp_bit("irq", 1'b1, irq);
		cmp_bit("system_reset", 1'b0, system_reset);
		irq_op(3'h1);
		cmp_bit("irq", 1'b0, irq);
		// Disable, then write the offset while the disable is crossing.
		@(posedge mclk);
		{ctrl_wr, ctrl_run_wdata} <= 2'b10;
		fire;
		wr_setup(s, t, ~o);
		repeat (60) if (sync_pending) @(posedge mclk);
		ec.run = 1'b0;
		ec.warning_offset_sel = ~o;
		cmp_cfg(ec);
		repeat (span(t)) @(posedge mclk);
		cmp_bit("system_reset", 1'b0, system_reset);
		wr_ctrl(1'b1, 1'b0, 1'b0);
		repeat (span(t)) if (!system_reset) @(posedge mclk);
		cmp_bit("system_reset", 1'b1, system_reset);
		nv.run = 1'b1;
		nv.timeout_length_sel = t;
		for (int i = 0; i < 4; i++) begin
			boot(nv);
			d = 8'($random(seed));
			restart(d == 8'hA5 ? 8'hA4 : d);
			cmp_bit("system_reset", 1'b1, system_reset);
		end
		nv.permanent_run_lock = 1'b1;
		boot(nv);
		wr_ctrl(1'b0, 1'b0, 1'b1);
		wr_setup(~s, ~t, ~o);
		irq_op(3'h4);
		ec = exp_cfg(nv);
		ec.window_mode_on = 1'b1;
		cmp_bit("permanent_run_lock", 1'b1, permanent_run_lock);
		cmp_bit("run_rdata", 1'b1, run_rdata);
		cmp_bit("window_mode_on", 1'b1, cfg_rdata.window_mode_on);
		cmp_cfg(ec);
		cmp_bit("early_warning_en", 1'b1, early_warning_en);
		// Window mode was switched on, so closed and open spans both pass.
		repeat (span(s) + span(t)) if (!system_reset) @(posedge mclk);
		cmp_bit("system_reset", 1'b1, system_reset);
		nv.permanent_run_lock = 1'b0;
		nv.window_mode_on = 1'b1;
		boot(nv);
		restart(8'hA5);
		repeat (8) if (!system_reset) @(posedge mclk);
		cmp_bit("system_reset", 1'b1, system_reset);
		boot(nv);
		irq_op(3'h4);
		repeat (span(s)) if (!early_warning_flag) @(posedge mclk);
		cmp_bit("early_warning_flag", 1'b1, early_warning_flag);
		restart(8'hA5);
		cmp_bit("system_reset", 1'b0, system_reset);
		end_of_test;
	end
endmodule
bind wdwt_top wdwt_top_checker u_chk (.mclk, .rst_n, .ctrl_wr, .restart_wr,
	.restart_wdata, .irq_enable_set_wr, .irq_enable_clear_wr, .bus_stall,
	.cfg_rdata, .permanent_run_lock, .early_warning_en, .early_warning_flag,
	.sync_pending, .irq, .system_reset);
